// [src/tmr_pkg.sv]
// package: register map, field layout and codes for the 16-bit timer
// Overview of operation
// - four-bit mode split over two control registers
// - normal and clear modes: immediate update, overflow MAX
// - phase-correct: update at TOP, overflow at BOTTOM
// - fast modes: update at TOP, overflow at TOP
// - phase-frequency modes: update and overflow at BOTTOM
// - optional filter needs four equal capture samples
// - edge select bit: zero falling, one rising
// - capture edge copies counter, sets capture flag
// - capture disabled while capture value is TOP
// - reserved control bit always reads zero
// - clock select: stop, direct, four prescaler taps
// - codes six and seven count external pin edges
// - external pin counted even when driven as output
// - force strobes act only in non-PWM modes
// - force applies match action to waveform output
// - force sets no flag, never clears counter
// - counter accessed as two bytes through latch
// - counter write blocks next match on all units
// - compare values checked against counter on each timer tick
// - compare writes go through the shared latch
package tmr_pkg;
	localparam logic [7:0]  ADDR_FLAGS    = 8'h6F;
	localparam logic [7:0]  ADDR_FORCE    = 8'h70;
	localparam logic [7:0]  ADDR_CAPCLK   = 8'h71;
	localparam logic [7:0]  ADDR_WAVE_A   = 8'h72;
	localparam logic [7:0]  ADDR_CNT_L    = 8'h74;
	localparam logic [7:0]  ADDR_CNT_H    = 8'h75;
	localparam logic [7:0]  ADDR_CAP_L    = 8'h76;
	localparam logic [7:0]  ADDR_CAP_H    = 8'h77;
	localparam logic [7:0]  ADDR_CMPA_L   = 8'h78;
	localparam logic [7:0]  ADDR_CMPA_H   = 8'h79;
	localparam logic [7:0]  ADDR_CMPB_L   = 8'h7A;
	localparam logic [7:0]  ADDR_CMPB_H   = 8'h7B;
	localparam logic [7:0]  RST_BYTE      = 8'h00;
	localparam logic [15:0] RST_WORD      = 16'h0000;
	localparam logic [9:0]  RST_PRE       = 10'h000;
	localparam logic [2:0]  RST_FILT      = 3'h0;
	localparam int          FORCE_A_BIT   = 7;
	localparam int          FORCE_B_BIT   = 6;
	localparam int          FILT_EN_BIT   = 7;
	localparam int          EDGE_SEL_BIT  = 6;
	localparam int          FLAG_OVF_BIT  = 7;
	localparam int          FLAG_MB_BIT   = 6;
	localparam int          FLAG_MA_BIT   = 5;
	localparam int          FLAG_CAP_BIT  = 3;
	localparam logic [7:0]  CAPCLK_MASK   = 8'hDF;
	localparam logic [7:0]  WAVE_A_MASK   = 8'hF3;
	localparam logic [7:0]  FLAGS_MASK    = 8'hE8;
	localparam logic [15:0] TOP_8B        = 16'h00FF;
	localparam logic [15:0] TOP_9B        = 16'h01FF;
	localparam logic [15:0] TOP_10B       = 16'h03FF;
	localparam logic [15:0] TOP_MAX       = 16'hFFFF;
	localparam logic [15:0] BOTTOM        = 16'h0000;
	localparam logic [9:0]  TAP_8_MASK    = 10'h007;
	localparam logic [9:0]  TAP_64_MASK   = 10'h03F;
	localparam logic [9:0]  TAP_256_MASK  = 10'h0FF;
	localparam logic [9:0]  TAP_1024_MASK = 10'h3FF;
	localparam int          FILTER_SAMPLES = 4;

	typedef enum logic [3:0] {
		MODE_NORMAL = 4'h0,
		MODE_PC8    = 4'h1,
		MODE_PC9    = 4'h2,
		MODE_PC10   = 4'h3,
		MODE_CLR_A  = 4'h4,
		MODE_FP8    = 4'h5,
		MODE_FP9    = 4'h6,
		MODE_FP10   = 4'h7,
		MODE_PFC_I  = 4'h8,
		MODE_PFC_A  = 4'h9,
		MODE_PC_I   = 4'hA,
		MODE_PC_A   = 4'hB,
		MODE_CLR_I  = 4'hC,
		MODE_RSVD   = 4'hD,
		MODE_FP_I   = 4'hE,
		MODE_FP_A   = 4'hF
	} tmr_mode_t;

	typedef enum logic [2:0] {
		CS_STOP     = 3'h0,
		CS_DIV1     = 3'h1,
		CS_DIV8     = 3'h2,
		CS_DIV64    = 3'h3,
		CS_DIV256   = 3'h4,
		CS_DIV1024  = 3'h5,
		CS_EXT_FALL = 3'h6,
		CS_EXT_RISE = 3'h7
	} tmr_clk_sel_t;

	typedef enum logic [1:0] {
		ACT_OFF    = 2'h0,
		ACT_TOGGLE = 2'h1,
		ACT_CLEAR  = 2'h2,
		ACT_SET    = 2'h3
	} tmr_action_t;
endpackage

// [src/tmr_pin_sync.sv]
// pin synchroniser: three flops, level changes when last two agree
`timescale 1ns/1ps
module tmr_pin_sync (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic pin,
	output logic      level
);
	logic s1;
	logic s2;
	logic s3;
	logic next_level;

	always_comb begin
		next_level = level;
		if (s2 == s3) begin
			next_level = s3;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1    <= 1'b0;
			s2    <= 1'b0;
			s3    <= 1'b0;
			level <= 1'b0;
		end else begin
			s1    <= pin;
			s2    <= s1;
			s3    <= s2;
			level <= next_level;
		end
	end
endmodule

// [src/tmr_timer16.sv]
// top: 16-bit timer control and data registers with counting core
`timescale 1ns/1ps
module tmr_timer16
	import tmr_pkg::*;
#(
	parameter int FILTER_LEN = FILTER_SAMPLES
) (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] io_addr,
	input  wire logic       io_wr,
	input  wire logic       io_rd,
	input  wire logic [7:0] io_wdata,
	output logic      [7:0] io_rdata,
	input  wire logic       capture_input_pin,
	input  wire logic       ext_count_pin,
	output logic            wave_out_a,
	output logic            wave_out_b,
	output logic            overflow_flag,
	output logic            capture_flag
);
	if (FILTER_LEN < 2 || FILTER_LEN > 8) begin : g_bad_len
		$error("FILTER_LEN must lie in 2..8");
	end

	logic [7:0]   wave_ctrl_a;
	logic [7:0]   capture_clock_ctrl;
	logic [7:0]   flags;
	logic [7:0]   temp;
	logic [7:0]   rdata;
	logic [15:0]  counter_value;
	logic [15:0]  compare_value_a;
	logic [15:0]  compare_value_b;
	logic [15:0]  cmp_buf_a;
	logic [15:0]  cmp_buf_b;
	logic [15:0]  capture_value;
	logic [9:0]   pre;
	logic [2:0]   filt_cnt;
	logic         count_down;
	logic         match_blk;
	logic         cap_prev;
	logic         ext_prev;
	logic         filt_out;
	logic         wave_a;
	logic         wave_b;

	logic [7:0]   next_wave_ctrl_a;
	logic [7:0]   next_capture_clock_ctrl;
	logic [7:0]   next_flags;
	logic [7:0]   next_temp;
	logic [7:0]   next_rdata;
	logic [15:0]  next_counter_value;
	logic [15:0]  next_compare_value_a;
	logic [15:0]  next_compare_value_b;
	logic [15:0]  next_cmp_buf_a;
	logic [15:0]  next_cmp_buf_b;
	logic [15:0]  next_capture_value;
	logic [9:0]   next_pre;
	logic [2:0]   next_filt_cnt;
	logic         next_count_down;
	logic         next_match_blk;
	logic         next_cap_prev;
	logic         next_filt_out;
	logic         next_wave_a;
	logic         next_wave_b;

	tmr_mode_t    waveform_mode_sel;
	tmr_clk_sel_t clock_source_sel;
	logic [15:0]  top;
	logic [7:0]   flag_set;
	logic [7:0]   flag_clr;
	logic         non_pwm;
	logic         fast;
	logic         pcor;
	logic         pfc;
	logic         icr_top;
	logic         tick;
	logic         at_top;
	logic         at_bot;
	logic         wrap;
	logic         upd;
	logic         ovf_set;
	logic         match_a;
	logic         match_b;
	logic         force_a;
	logic         force_b;
	logic         cap_sync;
	logic         ext_sync;
	logic         cap_src;
	logic         cap_edge;
	logic         cap_evt;
	logic         differ;

	tmr_pin_sync u_cap_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.pin      (capture_input_pin),
		.level    (cap_sync)
	);

	// pin is sampled whatever its port direction
	tmr_pin_sync u_ext_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.pin      (ext_count_pin),
		.level    (ext_sync)
	);

	// next level of a waveform output for one compare channel
	function automatic logic wave_step(
		input logic       cur,
		input logic [1:0] act,
		input logic       hit,
		input logic       frc,
		input logic       wrp,
		input logic       down,
		input logic       fst,
		input logic       pc,
		input logic       tog_ok
	);
		logic res;
		res = cur;
		if (!fst && !pc) begin
			if (hit || frc) begin
				case (act)
					ACT_TOGGLE: res = ~cur;
					ACT_CLEAR:  res = 1'b0;
					ACT_SET:    res = 1'b1;
					default:    res = cur;
				endcase
			end
		end else if (act == ACT_TOGGLE) begin
			if (hit && tog_ok) begin
				res = ~cur;
			end
		end else if (act != ACT_OFF) begin
			if (fst && wrp) begin
				res = (act == ACT_CLEAR);
			end else if (fst && hit) begin
				res = (act == ACT_SET);
			end else if (pc && hit) begin
				res = (act == ACT_SET) ^ down;
			end
		end
		return res;
	endfunction

	always_comb begin
		// mode decode
		waveform_mode_sel = tmr_mode_t'({capture_clock_ctrl[4:3],
			wave_ctrl_a[1:0]});
		clock_source_sel = tmr_clk_sel_t'(capture_clock_ctrl[2:0]);
		top = TOP_MAX;
		non_pwm = 1'b0;
		fast = 1'b0;
		pcor = 1'b0;
		pfc = 1'b0;
		icr_top = 1'b0;
		case (waveform_mode_sel)
			MODE_NORMAL: begin
				non_pwm = 1'b1;
			end
			MODE_CLR_A: begin
				non_pwm = 1'b1;
				top = compare_value_a;
			end
			MODE_CLR_I: begin
				non_pwm = 1'b1;
				top = capture_value;
				icr_top = 1'b1;
			end
			MODE_PC8, MODE_PC9, MODE_PC10: begin
				pcor = 1'b1;
				top = (waveform_mode_sel == MODE_PC8) ? TOP_8B :
					(waveform_mode_sel == MODE_PC9) ? TOP_9B : TOP_10B;
			end
			MODE_PC_I: begin
				pcor = 1'b1;
				top = capture_value;
				icr_top = 1'b1;
			end
			MODE_PC_A: begin
				pcor = 1'b1;
				top = compare_value_a;
			end
			MODE_FP8, MODE_FP9, MODE_FP10: begin
				fast = 1'b1;
				top = (waveform_mode_sel == MODE_FP8) ? TOP_8B :
					(waveform_mode_sel == MODE_FP9) ? TOP_9B : TOP_10B;
			end
			MODE_FP_I: begin
				fast = 1'b1;
				top = capture_value;
				icr_top = 1'b1;
			end
			MODE_FP_A: begin
				fast = 1'b1;
				top = compare_value_a;
			end
			MODE_PFC_I: begin
				pcor = 1'b1;
				pfc = 1'b1;
				top = capture_value;
				icr_top = 1'b1;
			end
			MODE_PFC_A: begin
				pcor = 1'b1;
				pfc = 1'b1;
				top = compare_value_a;
			end
			default: begin
				top = TOP_MAX;
			end
		endcase

		// timer clock source
		next_pre = pre + 10'h001;
		case (clock_source_sel)
			CS_DIV1:     tick = 1'b1;
			CS_DIV8:     tick = (pre & TAP_8_MASK) == TAP_8_MASK;
			CS_DIV64:    tick = (pre & TAP_64_MASK) == TAP_64_MASK;
			CS_DIV256:   tick = (pre & TAP_256_MASK) == TAP_256_MASK;
			CS_DIV1024:  tick = (pre & TAP_1024_MASK) == TAP_1024_MASK;
			CS_EXT_FALL: tick = ext_prev & ~ext_sync;
			CS_EXT_RISE: tick = ext_sync & ~ext_prev;
			default:     tick = 1'b0;
		endcase

		// capture path with optional filter
		differ = cap_sync != filt_out;
		next_filt_out = filt_out;
		next_filt_cnt = RST_FILT;
		if (differ) begin
			next_filt_cnt = filt_cnt + 3'h1;
			if (filt_cnt == 3'(FILTER_LEN - 1)) begin
				next_filt_out = cap_sync;
				next_filt_cnt = RST_FILT;
			end
		end
		cap_src = capture_clock_ctrl[FILT_EN_BIT] ? filt_out : cap_sync;
		next_cap_prev = cap_src;
		cap_edge = capture_clock_ctrl[EDGE_SEL_BIT] ?
			(cap_src & ~cap_prev) : (~cap_src & cap_prev);
		cap_evt = cap_edge & ~icr_top;

		// counting sequence
		at_top = counter_value == top;
		at_bot = counter_value == BOTTOM;
		match_a = tick & ~match_blk &
			(counter_value == compare_value_a);
		match_b = tick & ~match_blk &
			(counter_value == compare_value_b);
		next_counter_value = counter_value;
		next_count_down = count_down;
		next_match_blk = tick ? 1'b0 : match_blk;
		ovf_set = 1'b0;
		upd = 1'b0;
		wrap = 1'b0;
		if (tick && waveform_mode_sel != MODE_RSVD) begin
			if (pcor) begin
				if (!count_down) begin
					if (at_top) begin
						next_count_down = 1'b1;
						next_counter_value = counter_value - 16'h0001;
						upd = ~pfc;
					end else begin
						next_counter_value = counter_value + 16'h0001;
					end
				end else if (at_bot) begin
					next_count_down = 1'b0;
					next_counter_value = counter_value + 16'h0001;
					ovf_set = 1'b1;
					upd = pfc;
				end else begin
					next_counter_value = counter_value - 16'h0001;
				end
			end else begin
				wrap = fast & at_top;
				if (at_top && waveform_mode_sel != MODE_NORMAL) begin
					next_counter_value = BOTTOM;
				end else begin
					next_counter_value = counter_value + 16'h0001;
				end
				ovf_set = fast ? at_top :
					(counter_value == TOP_MAX);
				upd = fast & at_top;
			end
		end

		// register writes
		next_wave_ctrl_a = wave_ctrl_a;
		next_capture_clock_ctrl = capture_clock_ctrl;
		next_temp = temp;
		next_cmp_buf_a = cmp_buf_a;
		next_cmp_buf_b = cmp_buf_b;
		next_capture_value = cap_evt ? counter_value : capture_value;
		flag_clr = RST_BYTE;
		force_a = 1'b0;
		force_b = 1'b0;
		if (io_wr) begin
			if (io_addr == ADDR_WAVE_A) begin
				next_wave_ctrl_a = io_wdata & WAVE_A_MASK;
			end else if (io_addr == ADDR_CAPCLK) begin
				next_capture_clock_ctrl = io_wdata & CAPCLK_MASK;
			end else if (io_addr == ADDR_FORCE) begin
				force_a = io_wdata[FORCE_A_BIT] & non_pwm;
				force_b = io_wdata[FORCE_B_BIT] & non_pwm;
			end else if (io_addr == ADDR_FLAGS) begin
				flag_clr = io_wdata & FLAGS_MASK;
			end else if (io_addr == ADDR_CNT_L) begin
				next_counter_value = {temp, io_wdata};
				next_match_blk = 1'b1;
			end else if (io_addr == ADDR_CAP_L) begin
				next_capture_value = {temp, io_wdata};
			end else if (io_addr == ADDR_CMPA_L) begin
				next_cmp_buf_a = {temp, io_wdata};
			end else if (io_addr == ADDR_CMPB_L) begin
				next_cmp_buf_b = {temp, io_wdata};
			end else if (io_addr == ADDR_CNT_H || io_addr == ADDR_CAP_H ||
				io_addr == ADDR_CMPA_H || io_addr == ADDR_CMPB_H) begin
				next_temp = io_wdata;
			end
		end

		// active compare values
		if (non_pwm) begin
			next_compare_value_a = next_cmp_buf_a;
			next_compare_value_b = next_cmp_buf_b;
		end else if (upd) begin
			next_compare_value_a = cmp_buf_a;
			next_compare_value_b = cmp_buf_b;
		end else begin
			next_compare_value_a = compare_value_a;
			next_compare_value_b = compare_value_b;
		end

		// waveform outputs; forces act here only
		next_wave_a = wave_step(wave_a, wave_ctrl_a[7:6], match_a, force_a,
			wrap, count_down, fast, pcor,
			waveform_mode_sel[3]);
		next_wave_b = wave_step(wave_b, wave_ctrl_a[5:4], match_b, force_b,
			wrap, count_down, fast, pcor, 1'b0);

		// sticky flags, a set beats a clear
		flag_set = RST_BYTE;
		flag_set[FLAG_OVF_BIT] = ovf_set;
		flag_set[FLAG_MA_BIT] = match_a;
		flag_set[FLAG_MB_BIT] = match_b;
		flag_set[FLAG_CAP_BIT] = cap_evt |
			(icr_top & tick & at_top & ~count_down);
		next_flags = (flags & ~flag_clr) | flag_set;

		// read data, counter or capture low read latches the high byte
		next_rdata = rdata;
		if (io_rd) begin
			if (io_addr == ADDR_FLAGS) begin
				next_rdata = flags;
			end else if (io_addr == ADDR_CAPCLK) begin
				next_rdata = capture_clock_ctrl & CAPCLK_MASK;
			end else if (io_addr == ADDR_WAVE_A) begin
				next_rdata = wave_ctrl_a;
			end else if (io_addr == ADDR_CNT_L) begin
				next_rdata = counter_value[7:0];
				next_temp = counter_value[15:8];
			end else if (io_addr == ADDR_CAP_L) begin
				next_rdata = capture_value[7:0];
				next_temp = capture_value[15:8];
			end else if (io_addr == ADDR_CNT_H || io_addr == ADDR_CAP_H) begin
				next_rdata = temp;
			end else if (io_addr == ADDR_CMPA_L) begin
				next_rdata = cmp_buf_a[7:0];
			end else if (io_addr == ADDR_CMPA_H) begin
				next_rdata = cmp_buf_a[15:8];
			end else if (io_addr == ADDR_CMPB_L) begin
				next_rdata = cmp_buf_b[7:0];
			end else if (io_addr == ADDR_CMPB_H) begin
				next_rdata = cmp_buf_b[15:8];
			end else begin
				next_rdata = RST_BYTE;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wave_ctrl_a        <= RST_BYTE;
			capture_clock_ctrl <= RST_BYTE;
			flags              <= RST_BYTE;
			temp               <= RST_BYTE;
			rdata              <= RST_BYTE;
			counter_value      <= RST_WORD;
			compare_value_a    <= RST_WORD;
			compare_value_b    <= RST_WORD;
			cmp_buf_a          <= RST_WORD;
			cmp_buf_b          <= RST_WORD;
			capture_value      <= RST_WORD;
			pre                <= RST_PRE;
			filt_cnt           <= RST_FILT;
			count_down         <= 1'b0;
			match_blk          <= 1'b0;
			cap_prev           <= 1'b0;
			ext_prev           <= 1'b0;
			filt_out           <= 1'b0;
			wave_a             <= 1'b0;
			wave_b             <= 1'b0;
		end else begin
			wave_ctrl_a        <= next_wave_ctrl_a;
			capture_clock_ctrl <= next_capture_clock_ctrl;
			flags              <= next_flags;
			temp               <= next_temp;
			rdata              <= next_rdata;
			counter_value      <= next_counter_value;
			compare_value_a    <= next_compare_value_a;
			compare_value_b    <= next_compare_value_b;
			cmp_buf_a          <= next_cmp_buf_a;
			cmp_buf_b          <= next_cmp_buf_b;
			capture_value      <= next_capture_value;
			pre                <= next_pre;
			filt_cnt           <= next_filt_cnt;
			count_down         <= next_count_down;
			match_blk          <= next_match_blk;
			cap_prev           <= next_cap_prev;
			ext_prev           <= ext_sync;
			filt_out           <= next_filt_out;
			wave_a             <= next_wave_a;
			wave_b             <= next_wave_b;
		end
	end

	assign io_rdata      = rdata;
	assign wave_out_a    = wave_a;
	assign wave_out_b    = wave_b;
	assign overflow_flag = flags[FLAG_OVF_BIT];
	assign capture_flag  = flags[FLAG_CAP_BIT];
endmodule

// [verification/tmr_timer16_props.sv]
// checker: bus, register and flag relations at the timer ports
`timescale 1ns/1ps
module tmr_timer16_props
	import tmr_pkg::*;
#(
	parameter int FILTER_LEN = FILTER_SAMPLES
) (
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic [7:0] io_addr,
	input wire logic       io_wr,
	input wire logic       io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic       capture_input_pin,
	input wire logic       ext_count_pin,
	input wire logic       wave_out_a,
	input wire logic       wave_out_b,
	input wire logic       overflow_flag,
	input wire logic       capture_flag
);
	logic [7:0] sh_capclk;
	logic [7:0] sh_wave;
	logic [3:0] mode;
	logic       mapped;
	logic       nonpwm;
	logic       pwm;
	logic       flag_wr;
	assign mode    = {sh_capclk[4:3], sh_wave[1:0]};
	assign nonpwm  = mode inside {4'h0, 4'h4, 4'hC};
	assign pwm     = !nonpwm && mode != 4'hD;
	assign flag_wr = io_wr && io_addr == ADDR_FLAGS;
	assign mapped  = io_addr inside {[ADDR_FLAGS:ADDR_CMPB_H]}
		&& io_addr != 8'h73;
	// shadow of the control registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_capclk <= RST_BYTE;
			sh_wave   <= RST_BYTE;
		end else if (io_wr && io_addr == ADDR_CAPCLK) begin
			sh_capclk <= io_wdata;
		end else if (io_wr && io_addr == ADDR_WAVE_A) begin
			sh_wave <= io_wdata;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_stopped;
		sh_capclk[2:0] == CS_STOP ##1 sh_capclk[2:0] == CS_STOP;
	endsequence
	sequence s_read(logic [7:0] a);
		io_rd && io_addr == a;
	endsequence
	property p_unmapped;
		io_rd && !mapped |=> io_rdata == RST_BYTE;
	endproperty
	property p_force_zero;
		s_read(ADDR_FORCE) |=> io_rdata == RST_BYTE;
	endproperty
	property p_capclk_rd;
		s_read(ADDR_CAPCLK) |=> io_rdata == (sh_capclk & CAPCLK_MASK);
	endproperty
	property p_wave_rd;
		s_read(ADDR_WAVE_A) |=> io_rdata == (sh_wave & WAVE_A_MASK);
	endproperty
	property p_rdata_hold;
		!io_rd |=> $stable(io_rdata);
	endproperty
	property p_cap_sticky;
		capture_flag && !(flag_wr && io_wdata[FLAG_CAP_BIT])
			|=> capture_flag;
	endproperty
	property p_ovf_sticky;
		overflow_flag && !(flag_wr && io_wdata[FLAG_OVF_BIT])
			|=> overflow_flag;
	endproperty
	property p_ovf_stop;
		s_stopped |=> !$rose(overflow_flag);
	endproperty
	property p_pwm_force;
		s_stopped ##0 (io_wr && io_addr == ADDR_FORCE && pwm)
			|=> $stable(wave_out_a) && $stable(wave_out_b);
	endproperty
	property p_force_tog;
		s_stopped ##0 (io_wr && io_addr == ADDR_FORCE && nonpwm
			&& io_wdata[FORCE_A_BIT] && sh_wave[7:6] == ACT_TOGGLE)
			|=> wave_out_a != $past(wave_out_a);
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	a_force_zero: assert property (p_force_zero)
		else $error("force register read not zero");
	a_capclk_rd: assert property (p_capclk_rd)
		else $error("capture clock control readback wrong");
	a_wave_rd: assert property (p_wave_rd)
		else $error("wave control readback wrong");
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data moved without a read");
	a_cap_sticky: assert property (p_cap_sticky)
		else $error("capture flag dropped");
	a_ovf_sticky: assert property (p_ovf_sticky)
		else $error("overflow flag dropped");
	a_ovf_stop: assert property (p_ovf_stop)
		else $error("overflow with clock stopped");
	a_pwm_force: assert property (p_pwm_force)
		else $error("force acted in pwm mode");
	a_force_tog: assert property (p_force_tog)
		else $error("force did not toggle output a");
endmodule

// [verification/tmr_cpu_model.sv]
// processor core model: byte accesses on the internal register bus
`timescale 1ns/1ps
module tmr_cpu_model (
	input  wire logic       core_clk,
	input  wire logic [7:0] io_rdata,
	output logic      [7:0] io_addr,
	output logic            io_wr,
	output logic            io_rd,
	output logic      [7:0] io_wdata
);
	initial begin
		io_addr  = 8'h00;
		io_wr    = 1'b0;
		io_rd    = 1'b0;
		io_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		io_addr  = a;
		io_wdata = d;
		io_wr    = 1'b1;
		@(negedge core_clk);
		io_wr    = 1'b0;
		io_addr  = ~a;
		io_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		io_addr = a;
		io_rd   = 1'b1;
		@(negedge core_clk);
		io_rd   = 1'b0;
		io_addr = ~a;
		d       = io_rdata;
	endtask
	// high byte first, low byte commits
	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		wr(a + 8'h01, v[15:8]);
		wr(a, v[7:0]);
	endtask
	// low byte first, latches the high byte
	task automatic rd16(input logic [7:0] a, output logic [15:0] v);
		logic [7:0] lo;
		logic [7:0] hi;
		rd(a, lo);
		rd(a + 8'h01, hi);
		v = {hi, lo};
	endtask
endmodule

// [verification/testbench.sv]
// testbench: register sequences against the timer control block
`timescale 1ns/1ps
module testbench
	import tmr_pkg::*;
;
	logic        core_clk;
	logic        rst_n;
	logic [7:0]  io_addr;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  io_wdata;
	logic [7:0]  io_rdata;
	logic        capture_input_pin;
	logic        ext_count_pin;
	logic        wave_out_a;
	logic        wave_out_b;
	logic        overflow_flag;
	logic        capture_flag;
	int          mismatches;
	int          samples_checked;
	logic [15:0] v;
	logic [7:0]  b;
	logic        wa;
	localparam int          DIVS [5] = '{1, 8, 64, 256, 1024};
	localparam logic [7:0]  OV_WAVE [3] = '{8'h00, 8'h01, 8'h01};
	localparam logic [7:0]  OV_CC [3] = '{8'h01, 8'h09, 8'h01};
	localparam logic [15:0] OV_START [3] = '{16'hFFFD, 16'h00FD, 16'h00FD};
	localparam logic        OV_EARLY [3] = '{1'b1, 1'b1, 1'b0};
	tmr_timer16 #(.FILTER_LEN(FILTER_SAMPLES)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .capture_input_pin(capture_input_pin),
		.ext_count_pin(ext_count_pin), .wave_out_a(wave_out_a),
		.wave_out_b(wave_out_b), .overflow_flag(overflow_flag),
		.capture_flag(capture_flag)
	);
	tmr_cpu_model cpu (
		.core_clk(core_clk), .io_rdata(io_rdata), .io_addr(io_addr),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata)
	);
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#400000;
		mismatches++;
		tally_and_finish;
	end
	initial begin
		rst_n = 1'b0;
		capture_input_pin = 1'b0;
		ext_count_pin = 1'b0;
		mismatches = 0;
		samples_checked = 0;
		idle(4);
		rst_n = 1'b1;
		for (int a = 8'h6E; a <= 8'h7C; a++) begin
			cpu.rd(8'(a), b);
			check(16'(b), 16'h0000);
		end
		cpu.wr(ADDR_CAPCLK, 8'hFF);
		cpu.rd(ADDR_CAPCLK, b);
		check(16'(b), 16'(CAPCLK_MASK));
		cpu.wr(ADDR_CAPCLK, 8'h00);
		cpu.wr(ADDR_WAVE_A, 8'hFF);
		cpu.rd(ADDR_WAVE_A, b);
		check(16'(b), 16'(WAVE_A_MASK));
		cpu.wr(ADDR_WAVE_A, 8'h00);
		cpu.wr(8'h90, 8'hFF);
		cpu.rd(8'h90, b);
		check(16'(b), 16'h0000);
		cpu.wr16(ADDR_CNT_L, 16'h1234);
		cpu.wr(ADDR_CNT_H, 8'h77);
		idle(10);
		cpu.rd16(ADDR_CNT_L, v);
		check(v, 16'h1234);
		cpu.wr16(ADDR_CMPA_L, 16'hABCD);
		cpu.rd16(ADDR_CMPA_L, v);
		check(v, 16'hABCD);
		cpu.wr(ADDR_CMPB_H, 8'h5A);
		cpu.wr(ADDR_CMPB_L, 8'h11);
		cpu.wr(ADDR_CMPA_L, 8'h22);
		cpu.rd16(ADDR_CMPA_L, v);
		check(v, 16'h5A22);
		// direct clock and prescaled taps
		for (int i = 0; i < 5; i++) begin
			cpu.wr16(ADDR_CNT_L, 16'h0000);
			cpu.wr(ADDR_CAPCLK, 8'(i + 1));
			idle(4 * DIVS[i]);
			cpu.wr(ADDR_CAPCLK, 8'h00);
			cpu.rd16(ADDR_CNT_L, v);
			check(16'(v >= 16'h0004 && v <= 16'h0007), 16'h0001);
		end
		// external pin, rising then falling
		for (int e = 0; e < 2; e++) begin
			cpu.wr16(ADDR_CNT_L, 16'h0000);
			cpu.wr(ADDR_CAPCLK, 8'(7 - e));
			repeat (3) begin
				idle(4);
				ext_count_pin = 1'b1;
				idle(4);
				ext_count_pin = 1'b0;
			end
			idle(6);
			cpu.wr(ADDR_CAPCLK, 8'h00);
			cpu.rd16(ADDR_CNT_L, v);
			check(v, 16'h0003);
		end
		// overflow moment in normal, fast and phase-correct modes
		for (int i = 0; i < 3; i++) begin
			cpu.wr(ADDR_WAVE_A, OV_WAVE[i]);
			cpu.wr16(ADDR_CNT_L, OV_START[i]);
			cpu.wr(ADDR_FLAGS, 8'hFF);
			cpu.wr(ADDR_CAPCLK, OV_CC[i]);
			idle(20);
			check(16'(overflow_flag), 16'(OV_EARLY[i]));
			for (int k = 0; k < 600 && overflow_flag !== 1'b1; k++)
				idle(1);
			check(16'(overflow_flag), 16'h0001);
			cpu.wr(ADDR_CAPCLK, 8'h00);
		end
		cpu.wr(ADDR_WAVE_A, 8'h00);
		cpu.wr(ADDR_FLAGS, 8'h80);
		check(16'(overflow_flag), 16'h0000);
		// capture edges and filter
		cpu.wr16(ADDR_CNT_L, 16'h0100);
		cpu.wr(ADDR_CAPCLK, 8'h41);
		cpu.wr(ADDR_FLAGS, 8'hFF);
		capture_input_pin = 1'b1;
		idle(8);
		check(16'(capture_flag), 16'h0001);
		cpu.rd16(ADDR_CAP_L, v);
		check(16'(v > 16'h0100 && v < 16'h0130), 16'h0001);
		cpu.wr(ADDR_FLAGS, 8'h08);
		capture_input_pin = 1'b0;
		idle(8);
		check(16'(capture_flag), 16'h0000);
		cpu.wr(ADDR_CAPCLK, 8'hC1);
		capture_input_pin = 1'b1;
		idle(6);
		check(16'(capture_flag), 16'h0000);
		idle(6);
		check(16'(capture_flag), 16'h0001);
		cpu.wr(ADDR_CAPCLK, 8'h01);
		cpu.wr(ADDR_FLAGS, 8'h08);
		capture_input_pin = 1'b0;
		idle(8);
		check(16'(capture_flag), 16'h0001);
		cpu.wr(ADDR_CAPCLK, 8'h58);
		cpu.wr(ADDR_FLAGS, 8'h08);
		capture_input_pin = 1'b1;
		idle(8);
		check(16'(capture_flag), 16'h0000);
		cpu.wr(ADDR_CAPCLK, 8'h00);
		// counter write blocks the next match
		cpu.wr16(ADDR_CMPA_L, 16'h0040);
		cpu.wr(ADDR_CAPCLK, 8'h01);
		cpu.wr(ADDR_FLAGS, 8'hFF);
		cpu.wr16(ADDR_CNT_L, 16'h0040);
		idle(4);
		cpu.rd(ADDR_FLAGS, b);
		check(16'(b[FLAG_MA_BIT]), 16'h0000);
		cpu.wr16(ADDR_CNT_L, 16'h003C);
		idle(8);
		cpu.rd(ADDR_FLAGS, b);
		check(16'(b[FLAG_MA_BIT]), 16'h0001);
		cpu.wr(ADDR_CAPCLK, 8'h00);
		// phase-frequency, then clear on compare a
		cpu.wr(ADDR_WAVE_A, 8'h01);
		cpu.wr16(ADDR_CNT_L, 16'h003E);
		cpu.wr(ADDR_FLAGS, 8'hFF);
		cpu.wr(ADDR_CAPCLK, 8'h11);
		idle(20);
		check(16'(overflow_flag), 16'h0000);
		idle(60);
		check(16'(overflow_flag), 16'h0001);
		cpu.wr(ADDR_WAVE_A, 8'h00);
		cpu.wr(ADDR_CAPCLK, 8'h09);
		idle(70);
		cpu.wr(ADDR_CAPCLK, 8'h00);
		cpu.rd16(ADDR_CNT_L, v);
		check(16'(v <= 16'h0040), 16'h0001);
		// forced compare
		cpu.wr(ADDR_FLAGS, 8'hFF);
		cpu.wr(ADDR_WAVE_A, 8'h70);
		wa = wave_out_a;
		cpu.wr(ADDR_FORCE, 8'hC0);
		check(16'({wave_out_a, wave_out_b}), 16'({~wa, 1'b1}));
		cpu.rd(ADDR_FLAGS, b);
		check(16'(b), 16'h0000);
		cpu.wr(ADDR_WAVE_A, 8'h71);
		wa = wave_out_a;
		cpu.wr(ADDR_FORCE, 8'h80);
		check(16'(wave_out_a), 16'(wa));
		cpu.wr(ADDR_WAVE_A, 8'h00);
		tally_and_finish;
	end
endmodule
bind tmr_timer16 tmr_timer16_props #(.FILTER_LEN(FILTER_LEN)) u_props (
	.core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr),
	.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
	.io_rdata(io_rdata), .capture_input_pin(capture_input_pin),
	.ext_count_pin(ext_count_pin), .wave_out_a(wave_out_a),
	.wave_out_b(wave_out_b), .overflow_flag(overflow_flag),
	.capture_flag(capture_flag)
);
